// ---- clock_error_irq_status.sv ----
// raw clock error and output fault status bank with two interrupt lines
//
// The APB register port is this design's own decision.
`timescale 1ns/100ps
module clock_error_irq_status (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [irq_status_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [irq_status_pkg::DATA_W-1:0] pwdata,
  output logic [irq_status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [irq_status_pkg::REG_W-1:0] overrate_a_src,
  input wire logic [irq_status_pkg::REG_W-1:0] overrate_b_src,
  input wire logic [irq_status_pkg::REG_W-1:0] underrate_src,
  input wire logic [irq_status_pkg::REG_W-1:0] fault_src,
  output logic any_overrate_summary,
  output logic any_underrate_summary,
  output logic second_line_state,
  output logic irq
);
  import irq_status_pkg::*;

  typedef struct packed {
    logic [EVT_W-1:0] evt;
    logic [EVT_W-1:0] first_mask;
    logic [EVT_W-1:0] second_mask;
    logic [EVT_W-1:0] prev;
    logic [1:0] settle;
  } ctl_t;

  ctl_t ctl_q, ctl_d;
  logic [4*REG_W-1:0] synced;
  logic [REG_W-1:0] overrate_a_view;
  logic [REG_W-1:0] overrate_b_view;
  logic [REG_W-1:0] underrate_view;
  logic [REG_W-1:0] fault_view;
  logic [EVT_W-1:0] condition;
  logic [EVT_W-1:0] rise;
  logic [EVT_W-1:0] clear;
  logic [13:0] idx;
  logic aligned;
  logic hit;
  logic wr_stb;
  logic [DATA_W-1:0] rd_data;
  logic first_line_state;
  logic [REG_W-1:0] line_view;

  // places a register value in the low half of a bus word
  function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
    widen = {16'h0000, v};
  endfunction

  // places an event-wide value in the low bits of a bus word
  function automatic logic [DATA_W-1:0] widen_evt(input logic [EVT_W-1:0] v);
    widen_evt = {26'h0000000, v};
  endfunction

  // all live sources cross into the bus clock domain
  bit_sync #(
    .WIDTH(4 * REG_W)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({fault_src, underrate_src, overrate_b_src, overrate_a_src}),
    .sync_out(synced)
  );

  // live views, unlatched; unimplemented bits read zero
  assign overrate_a_view = synced[REG_W-1:0] & OVERRATE_A_BITS;
  assign overrate_b_view = synced[2*REG_W-1:REG_W] & OVERRATE_B_BITS;
  assign underrate_view = synced[3*REG_W-1:2*REG_W] & UNDERRATE_BITS;
  assign fault_view = synced[4*REG_W-1:3*REG_W] & FAULT_BITS;

  // summary flags of the overrate and underrate groups
  assign any_overrate_summary = |overrate_a_view || |overrate_b_view;
  assign any_underrate_summary = |underrate_view;

  // conditions that raise sticky events on their rising edge
  always_comb begin
    condition = '0;
    condition[EV_OVERRATE] = any_overrate_summary;
    condition[EV_UNDERRATE] = any_underrate_summary;
    condition[EV_CUTOFF] = fault_view[SPEAKER_CUTOFF_FLAG];
    condition[EV_SPK_SHORT] = fault_view[SPEAKER_SHORT_FLAG];
    condition[EV_RIGHT_SHORT] = fault_view[RIGHT_PHONE_SHORT_FLAG];
    condition[EV_LEFT_SHORT] = fault_view[LEFT_PHONE_SHORT_FLAG];
  end

  assign rise = condition & ~ctl_q.prev;

  // the two interrupt lines
  assign first_line_state = |(ctl_q.evt & ctl_q.first_mask);
  assign second_line_state = |(ctl_q.evt & ctl_q.second_mask);
  assign irq = first_line_state;

  always_comb begin
    line_view = '0;
    line_view[FIRST_LINE_STATE] = first_line_state;
    line_view[SECOND_LINE_STATE] = second_line_state;
  end

  // address decode of the current request
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'b00);

  always_comb begin
    hit = aligned;
    rd_data = PRDATA_RESET;
    if (idx == OVERRATE_A_IDX) begin
      rd_data = widen(overrate_a_view);
    end else if (idx == OVERRATE_B_IDX) begin
      rd_data = widen(overrate_b_view);
    end else if (idx == UNDERRATE_IDX) begin
      rd_data = widen(underrate_view);
    end else if (idx == FAULT_IDX) begin
      rd_data = widen(fault_view);
    end else if (idx == LINE_IDX) begin
      rd_data = widen(line_view);
    end else if (idx == SUMMARY_IDX) begin
      rd_data = {30'h00000000, any_underrate_summary, any_overrate_summary};
    end else if (idx == EVENT_IDX) begin
      rd_data = widen_evt(ctl_q.evt);
    end else if (idx == FIRST_MASK_IDX) begin
      rd_data = widen_evt(ctl_q.first_mask);
    end else if (idx == SECOND_MASK_IDX) begin
      rd_data = widen_evt(ctl_q.second_mask);
    end else begin
      hit = 1'b0;
    end
  end

  apb_reg_port u_port (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .hit(hit),
    .rd_data(rd_data),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .wr_stb(wr_stb)
  );

  // write one to clear on the event register
  assign clear = (wr_stb && idx == EVENT_IDX) ? pwdata[EVT_W-1:0] : '0;

  // next state: events, masks, edge history, settle count
  always_comb begin
    ctl_d = ctl_q;
    ctl_d.prev = condition;
    ctl_d.evt = (ctl_q.evt & ~clear) | rise; // set wins over clear
    if (wr_stb && idx == FIRST_MASK_IDX) begin
      ctl_d.first_mask = pwdata[EVT_W-1:0];
    end
    if (wr_stb && idx == SECOND_MASK_IDX) begin
      ctl_d.second_mask = pwdata[EVT_W-1:0];
    end
    if (ctl_q.settle != 2'h3) begin
      ctl_d.settle = ctl_q.settle + 2'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q <= '{evt: EVT_RESET, first_mask: MASK_RESET, second_mask: MASK_RESET,
                 prev: EVT_RESET, settle: 2'h0};
    end else begin
      ctl_q <= ctl_d;
    end
  end

  // checks on the status bank
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  overrate_a_map_a: assert property (ctl_q.settle == 2'h3 |->
      overrate_a_view == ($past(overrate_a_src, 2) & OVERRATE_A_BITS))
    else $error("overrate five does not follow its sources");

  overrate_b_map_a: assert property (ctl_q.settle == 2'h3 |->
      overrate_b_view == ($past(overrate_b_src, 2) & OVERRATE_B_BITS))
    else $error("overrate six does not follow its sources");

  underrate_map_a: assert property (ctl_q.settle == 2'h3 |->
      underrate_view == ($past(underrate_src, 2) & UNDERRATE_BITS))
    else $error("underrate seven does not follow its sources");

  over_summary_a: assert property (any_overrate_summary ==
      ((overrate_a_view | overrate_b_view) != 16'h0000))
    else $error("overrate summary disagrees with its bits");

  under_summary_a: assert property (any_underrate_summary == (underrate_view != 16'h0000))
    else $error("underrate summary disagrees with its bits");

  cutoff_flag_a: assert property (ctl_q.settle == 2'h3 |->
      fault_view[SPEAKER_CUTOFF_FLAG] == $past(fault_src[SPEAKER_CUTOFF_FLAG], 2))
    else $error("speaker cutoff flag lags its source");

  speaker_short_a: assert property ($rose(fault_view[SPEAKER_SHORT_FLAG]) |->
      ##1 ctl_q.evt[EV_SPK_SHORT])
    else $error("speaker short did not raise its event");

  phone_short_a: assert property (ctl_q.settle == 2'h3 |->
      {fault_view[RIGHT_PHONE_SHORT_FLAG], fault_view[LEFT_PHONE_SHORT_FLAG]} ==
      {$past(fault_src[RIGHT_PHONE_SHORT_FLAG], 2), $past(fault_src[LEFT_PHONE_SHORT_FLAG], 2)})
    else $error("headphone short flags lag their sources");

  second_line_a: assert property (second_line_state ==
      ((ctl_q.evt & ctl_q.second_mask) != 6'h00))
    else $error("second line state is not the unmasked event or");

  first_line_a: assert property (irq == ((ctl_q.evt & ctl_q.first_mask) != 6'h00))
    else $error("first line state is not the unmasked event or");

  settle_zero_a: assert property (ctl_q.settle != 2'h3 |->
      (overrate_a_view | overrate_b_view | underrate_view | fault_view) == 16'h0000)
    else $error("raw status not zero right after reset");

  raw_write_a: assert property (psel && !penable && pwrite && paddr[1:0] == 2'b00 &&
      (idx == OVERRATE_A_IDX || idx == FAULT_IDX) |=> !pslverr && $stable(ctl_q.evt & ~condition))
    else $error("write to a raw register was refused or had an effect");

  set_wins_a: assert property (rise[EV_OVERRATE] |=> ctl_q.evt[EV_OVERRATE])
    else $error("overrate event lost against a clear");

  overrate_seen_c: cover property (rise[EV_OVERRATE] ##1 irq);
  clear_event_c: cover property (wr_stb && idx == EVENT_IDX && ctl_q.evt != 6'h00);
  unmapped_c: cover property (pslverr);
  second_line_c: cover property ($rose(second_line_state));
endmodule

// ---- irq_status_pkg.sv ----
// constants and register map for the clock error and fault status bank
// How it works
// - raw status five shows overrate errors on bits 12, 10, 9, 7, 6..4, 3..1 and 0, one per subsystem.
// - the overrate summary is high whenever any overrate bit of raw status five or six is high.
// - raw status six shows overrate errors on bits 12..9, 7, 5 and 2..0.
// - raw status seven shows underrate errors on bits 10..8, 7..5, 4, 3, 2 and 0.
// - the underrate summary is high whenever any underrate bit of raw status seven is high.
// - raw status eight bit 14 is high once the speaker has completed a fault shutdown.
// - raw status eight bit 12 is high while a speaker short circuit is detected.
// - raw status eight bits 2 and 0 are high while the right or left headphone is shorted.
// - line status bit 1 is the OR of all unmasked events routed to the second line.
// - line status bit 0 is the OR of all unmasked events routed to the first line.
package irq_status_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  // register indices; byte address is four times the index
  localparam logic [13:0] OVERRATE_A_IDX = 14'h0D24;
  localparam logic [13:0] OVERRATE_B_IDX = 14'h0D25;
  localparam logic [13:0] UNDERRATE_IDX = 14'h0D26;
  localparam logic [13:0] FAULT_IDX = 14'h0D28;
  localparam logic [13:0] LINE_IDX = 14'h0D40;
  localparam logic [13:0] SUMMARY_IDX = 14'h0D30;
  localparam logic [13:0] EVENT_IDX = 14'h0D31;
  localparam logic [13:0] FIRST_MASK_IDX = 14'h0D32;
  localparam logic [13:0] SECOND_MASK_IDX = 14'h0D33;
  // implemented bits of each raw register
  localparam logic [15:0] OVERRATE_A_BITS = 16'h16FF;
  localparam logic [15:0] OVERRATE_B_BITS = 16'h1EA7;
  localparam logic [15:0] UNDERRATE_BITS = 16'h07FD;
  localparam logic [15:0] FAULT_BITS = 16'h5005;
  // named field positions
  localparam int EFFECTS_CORE_OVERRATE = 12;
  localparam int DAC_SYSTEM_OVERRATE = 10;
  localparam int DAC_FAST_OVERRATE = 9;
  localparam int MIX_ENGINE_OVERRATE = 7;
  localparam int PAD_LOGIC_OVERRATE = 0;
  localparam int CORE_THREE_OVERRATE = 7;
  localparam int CORE_TWO_OVERRATE = 5;
  localparam int SPEAKER_CUTOFF_FLAG = 14;
  localparam int SPEAKER_SHORT_FLAG = 12;
  localparam int RIGHT_PHONE_SHORT_FLAG = 2;
  localparam int LEFT_PHONE_SHORT_FLAG = 0;
  localparam int FIRST_LINE_STATE = 0;
  localparam int SECOND_LINE_STATE = 1;
  // sticky event bits
  localparam int EVT_W = 6;
  localparam int EV_OVERRATE = 0;
  localparam int EV_UNDERRATE = 1;
  localparam int EV_CUTOFF = 2;
  localparam int EV_SPK_SHORT = 3;
  localparam int EV_RIGHT_SHORT = 4;
  localparam int EV_LEFT_SHORT = 5;
  // reset values
  localparam logic [EVT_W-1:0] EVT_RESET = 6'h00;
  localparam logic [EVT_W-1:0] MASK_RESET = 6'h00;
  localparam logic [DATA_W-1:0] PRDATA_RESET = 32'h00000000;
  // synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;
endpackage

// ---- bit_sync.sv ----
// two flip-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/100ps
module bit_sync #(
  parameter int WIDTH = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_t;
  sync_t state_q, state_d;

  initial begin
    if (WIDTH < 1) $error("bit_sync needs a width of at least one");
  end

  // first stage feeds only the second
  always_comb begin
    state_d = state_q;
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stable;
endmodule

// ---- apb_reg_port.sv ----
// zero wait state apb slave front end with registered read data
`timescale 1ns/100ps
module apb_reg_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic hit,
  input wire logic [irq_status_pkg::DATA_W-1:0] rd_data,
  output logic [irq_status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic wr_stb
);
  import irq_status_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic err;
  } port_t;
  port_t port_q, port_d;

  // capture read word and decode result in the setup cycle
  always_comb begin
    port_d = port_q;
    if (psel && !penable) begin
      port_d.rdata = (pwrite || !hit) ? PRDATA_RESET : rd_data;
      port_d.err = !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= '{rdata: PRDATA_RESET, err: 1'b0};
    end else begin
      port_q <= port_d;
    end
  end

  // access phase always completes at once
  assign pready = 1'b1;
  assign pslverr = psel && penable && port_q.err;
  assign wr_stb = psel && penable && pwrite && !port_q.err;
  assign prdata = port_q.rdata;
endmodule

// ---- apb_host.sv ----
// apb host model issuing single transfers to the status bank
`timescale 1ns/100ps
module apb_host (
  input wire logic pclk,
  output logic [irq_status_pkg::ADDR_W-1:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [irq_status_pkg::DATA_W-1:0] pwdata,
  input wire logic [irq_status_pkg::DATA_W-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import irq_status_pkg::*;
  logic [DATA_W-1:0] rd_q;
  logic err_q;
  // idle bus at time zero
  initial begin
    paddr = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = '0;
  end
  // setup then access, held until pready is seen high or 50 cycles have passed
  task automatic xfer(input logic wr, input logic [13:0] idx, input logic [DATA_W-1:0] wd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~wd; // released data does not keep its value
  endtask
endmodule

// ---- testbench.sv ----
// self-checking bench for the clock error and fault status bank
`timescale 1ns/100ps
module testbench;
  import irq_status_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr;
  logic psel, penable, pwrite, pready, pslverr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic [REG_W-1:0] ov_a = '0;
  logic [REG_W-1:0] ov_b = '0;
  logic [REG_W-1:0] und = '0;
  logic [REG_W-1:0] flt = '0;
  logic ov_sum, und_sum, line2, irq;
  int n_mismatch = 0;
  int checks_done = 0;
  logic [13:0] idx_tab [9] = '{OVERRATE_A_IDX, OVERRATE_B_IDX, UNDERRATE_IDX, FAULT_IDX, LINE_IDX,
    SUMMARY_IDX, EVENT_IDX, FIRST_MASK_IDX, SECOND_MASK_IDX};
  int fb [5] = '{14, 13, 12, 2, 0};
  apb_host host_u (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  clock_error_irq_status dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .overrate_a_src(ov_a), .overrate_b_src(ov_b), .underrate_src(und),
    .fault_src(flt), .any_overrate_summary(ov_sum), .any_underrate_summary(und_sum),
    .second_line_state(line2), .irq(irq));
  // 10 MHz clock
  always #50 pclk = ~pclk;
  // verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare of a bus word
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // compare of a single flag
  task automatic chk_flag(input string what, input logic exp, input logic got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, exp, got);
    end
  endtask
  // read and compare one register
  task automatic rd(input logic [13:0] idx, input logic [31:0] exp);
    host_u.xfer(1'b0, idx, '0);
    chk_word($sformatf("reg %h", idx), exp, host_u.rd_q);
  endtask
  task automatic wr(input logic [13:0] idx, input logic [31:0] d);
    host_u.xfer(1'b1, idx, d);
  endtask
  // sync plus sticky event latency with margin
  task automatic settle;
    repeat (4) @(posedge pclk);
  endtask
  // watchdog
  initial begin
    #(100 * 5000);
    n_mismatch++;
    $display("[ERR] watchdog expired");
    close_out();
  end
  // main sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) rd(idx_tab[i], 32'h0);
    wr(OVERRATE_A_IDX, 32'h0000FFFF);
    chk_flag("write err", 1'b0, host_u.err_q);
    rd(OVERRATE_A_IDX, 32'h0);
    $display("test reset done");
    ov_a <= 16'hFFFF;
    settle();
    rd(OVERRATE_A_IDX, 32'h16FF);
    chk_flag("ov sum", 1'b1, ov_sum);
    ov_a <= 16'h0000;
    ov_b <= 16'hFFFF;
    settle();
    rd(OVERRATE_A_IDX, 32'h0);
    rd(OVERRATE_B_IDX, 32'h1EA7);
    chk_flag("ov sum", 1'b1, ov_sum);
    ov_b <= 16'h0000;
    und <= 16'hFFFF;
    settle();
    chk_flag("ov sum", 1'b0, ov_sum);
    rd(UNDERRATE_IDX, 32'h07FD);
    chk_flag("und sum", 1'b1, und_sum);
    und <= 16'h0000;
    settle();
    chk_flag("und sum", 1'b0, und_sum);
    for (int i = 0; i < 5; i++) begin
      flt <= 16'h1 << fb[i];
      settle();
      rd(FAULT_IDX, 32'(16'h5005 & (16'h1 << fb[i])));
    end
    flt <= 16'h0000;
    settle();
    rd(FAULT_IDX, 32'h0);
    $display("test raw views done");
    chk_flag("irq", 1'b0, irq);
    rd(LINE_IDX, 32'h0);
    wr(FIRST_MASK_IDX, 32'h3F);
    rd(LINE_IDX, 32'h1);
    chk_flag("irq", 1'b1, irq);
    wr(SECOND_MASK_IDX, 32'h04);
    rd(LINE_IDX, 32'h3);
    chk_flag("line2", 1'b1, line2);
    wr(EVENT_IDX, 32'h3F);
    rd(LINE_IDX, 32'h0);
    chk_flag("irq", 1'b0, irq);
    wr(FIRST_MASK_IDX, 32'h02);
    ov_a <= 16'h0001;
    settle();
    chk_flag("irq", 1'b0, irq);
    rd(EVENT_IDX, 32'h01);
    und <= 16'h0001;
    settle();
    chk_flag("irq", 1'b1, irq);
    chk_flag("line2", 1'b0, line2);
    rd(LINE_IDX, 32'h1);
    $display("test interrupts done");
    rd(14'h0D27, 32'h0);
    chk_flag("unmapped err", 1'b1, host_u.err_q);
    $display("test unmapped done");
    close_out();
  end
endmodule
